// ==== atr_chip_model.sv ====
// Behavioural model of the battery-backed clock chip controller.
`timescale 1ns/1ps

module atr_chip_model import atr_pkg::*; #(
  parameter atr_time_t BOOT_TIME = '0,
  parameter int        RD_LAT    = 3,
  parameter int        WR_LAT    = 40
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // Test control
  input  wire logic      time_ok,
  // Read side
  input  wire logic      chip_rd_req,
  output logic           chip_rd_ack,
  output atr_time_t      chip_rd_time,
  output logic           chip_rd_ok,
  // Write side
  input  wire logic      chip_wr_req,
  input  wire atr_time_t chip_wr_time,
  output logic           chip_wr_ack
);
  int rd_cnt;
  int wr_cnt;

  // Outside the ack cycle the read lines carry the inverse so a stale capture shows.
  assign chip_rd_time = chip_rd_ack ? BOOT_TIME : ~BOOT_TIME;
  assign chip_rd_ok   = chip_rd_ack ? time_ok : ~time_ok;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_cnt      <= 0;
      wr_cnt      <= 0;
      chip_rd_ack <= 1'b0;
      chip_wr_ack <= 1'b0;
    end else begin
      chip_rd_ack <= chip_rd_req && !chip_rd_ack && rd_cnt == RD_LAT - 1;
      rd_cnt      <= (chip_rd_req && !chip_rd_ack) ? rd_cnt + 1 : 0;
      // The write ack comes late on purpose, as a slow chip update would.
      chip_wr_ack <= chip_wr_req && !chip_wr_ack && wr_cnt == WR_LAT - 1;
      wr_cnt      <= (chip_wr_req && !chip_wr_ack) ? wr_cnt + 1 : 0;
    end
  end
endmodule

// ==== atr_clock.sv ====
// ASCII time set and request block with its reply FIFO.
//
// Notes on behaviour
// - Act only on A-Z, digits, /, LF.
// - Delimiter is byte 10 or byte 47.
// - Hours kept 00 to 23, 24-hour day.
// - Set is S, digits, delimiter; order configurable.
// - Short set fills rightmost groups, keeps others.
// - Odd digit count raises error, no change; over ten digits errors but still loads.
// - Valid set adds 10 ms, loads time, chip.
// - Slow chip update never stalls time keeping.
// - Range check minutes, seconds, hours, months.
// - Day checked against month length.
// - Out of range group errors, time kept.
// - Day without month checks stored month.
// - Reply five two-digit groups colon separated.
// - Reply starts first group, ends with LF.
// - Request snapshots time, held until read.
// - New instruction drops remaining reply bytes.
// - Lost time replies 88:88:88:88 LF, error.
// - Advance ignores leap year; Feb 29 settable.
// - Time advanced on own 1 ms tick.
// - Reset loads time from backup chip.
`timescale 1ns/1ps

module atr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  // Discard all contents
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             full_q, full_d, nemp_q, nemp_d;
  logic             push, pop;

  assign push      = in_valid && !full_q && !flush;
  assign pop       = nemp_q && out_ready && !flush;
  assign in_ready  = !full_q;
  assign out_valid = nemp_q;
  assign out_data  = mem[rp_q];

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
    full_d = (cnt_d == (AW+1)'(DEPTH));
    nemp_d = (cnt_d != '0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
      nemp_q <= 1'b0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      full_q <= full_d;
      nemp_q <= nemp_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

module atr_clock import atr_pkg::*; #(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Host command bytes
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  // Host reply bytes
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  input  wire logic       tx_ready,
  // Date order strap, high selects month first
  input  wire logic       date_us,
  // Error indication and its query clear
  output logic            err,
  input  wire logic       err_clr,
  // Backup clock chip controller
  output logic            chip_rd_req,
  input  wire logic       chip_rd_ack,
  input  wire atr_time_t  chip_rd_time,
  input  wire logic       chip_rd_ok,
  output logic            chip_wr_req,
  output atr_time_t       chip_wr_time,
  input  wire logic       chip_wr_ack
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [6:0] max_day(input logic [6:0] mon, input logic run);
    case (mon)
      7'h02:                      max_day = run ? DAY_FEB_RUN : DAY_FEB_SET;
      7'h04, 7'h06, 7'h09, 7'h0b: max_day = DAY_SHORT;
      default:                    max_day = DAY_LONG;
    endcase
  endfunction

  function automatic logic time_ok(input atr_time_t t);
    time_ok = (t.sec <= SEC_MAX) && (t.min <= SEC_MAX) && (t.hr <= HR_MAX)
           && (t.mon != 7'h00) && (t.mon <= MON_MAX)
           && (t.day != 7'h00) && (t.day <= max_day(t.mon, 1'b0));
  endfunction

  function automatic atr_time_t advance(input atr_time_t t);
    advance = t;
    if (t.ms != MS_MAX) begin
      advance.ms = t.ms + 10'h001;
    end else begin
      advance.ms = '0;
      if (t.sec != SEC_MAX) advance.sec = t.sec + 7'h01;
      else begin
        advance.sec = '0;
        if (t.min != SEC_MAX) advance.min = t.min + 7'h01;
        else begin
          advance.min = '0;
          if (t.hr != HR_MAX) advance.hr = t.hr + 7'h01;
          else begin
            advance.hr = '0;
            if (t.day < max_day(t.mon, 1'b1)) advance.day = t.day + 7'h01;
            else begin
              advance.day = 7'h01;
              advance.mon = (t.mon >= MON_MAX) ? 7'h01 : t.mon + 7'h01;
            end
          end
        end
      end
    end
  endfunction

  function automatic logic [7:0] group_char(input logic [6:0] v, input logic [1:0] pos);
    logic [6:0] tens;
    tens = v / 7'd10;
    case (pos)
      2'd0:    group_char = CH_0 + {1'b0, tens};
      2'd1:    group_char = CH_0 + {1'b0, v - 7'(tens * 7'd10)};
      default: group_char = CH_COL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  atr_state_t       st_q, st_d;
  atr_time_t        tm_q, tm_d, wr_q, wr_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic             ord_s1_q, ord_s2_q, ord_q, ord_d;
  logic             lost_q, lost_d, err_q, err_d;
  logic             rd_req_q, rd_req_d, wr_req_q, wr_req_d, rxr_q, rxr_d;
  logic             set_q, set_d, hi_q, hi_d;
  logic [3:0]       hv_q, hv_d, dcnt_q, dcnt_d;
  logic [6:0]       grp_q [NGRP], grp_d [NGRP];
  logic [6:0]       snap_q [NGRP], snap_d [NGRP];
  logic             rp_q, rp_d, bad_q, bad_d;
  logic [2:0]       rg_q, rg_d;
  logic [1:0]       rpos_q, rpos_d;
  logic [7:0]       fb;
  logic             f_ready, flush;
  logic [6:0]       cur [NGRP], nv [NGRP];
  atr_time_t        nt;
  logic             take, is_dig, is_up, is_dl, last;

  assign take   = rx_valid && rxr_q;
  assign is_up  = (rx_data >= CH_A) && (rx_data <= CH_Z);
  assign is_dig = (rx_data >= CH_0) && (rx_data <= CH_9);
  assign is_dl  = (rx_data == CH_LF) || (rx_data == CH_SL);
  assign flush  = take && is_up;
  assign last   = bad_q ? (rg_q == 3'd3) : (rg_q == 3'd4);

  atr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (rp_q),
    .in_data   (fb),
    .in_ready  (f_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready),
    .flush     (flush)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;  tm_d = tm_q;  wr_d = wr_q;  tick_d = tick_q;
    ord_d = ord_q;  lost_d = lost_q;  err_d = err_q;
    rd_req_d = rd_req_q;  wr_req_d = wr_req_q;  rxr_d = rxr_q;
    set_d = set_q;  hi_d = hi_q;  hv_d = hv_q;  dcnt_d = dcnt_q;
    rp_d = rp_q;  bad_d = bad_q;  rg_d = rg_q;  rpos_d = rpos_q;
    grp_d = grp_q;  snap_d = snap_q;
    cur[0] = tm_q.sec;  cur[1] = tm_q.min;  cur[2] = tm_q.hr;
    cur[3] = ord_q ? tm_q.day : tm_q.mon;
    cur[4] = ord_q ? tm_q.mon : tm_q.day;
    for (int i = 0; i < NGRP; i++) begin
      nv[i] = (4'(i) < dcnt_q[3:1]) ? grp_q[i] : cur[i];
    end
    nt = tm_q;
    nt.sec = nv[0];  nt.min = nv[1];  nt.hr = nv[2];
    nt.day = ord_q ? nv[3] : nv[4];
    nt.mon = ord_q ? nv[4] : nv[3];
    nt.ms  = SET_COMP_MS;
    fb = bad_q ? ((rpos_q == 2'd2) ? CH_COL : CH_8) : group_char(snap_q[rg_q], rpos_q);
    if (last && rpos_q == 2'd2) fb = CH_LF;
    if (err_clr) err_d = 1'b0;

    case (st_q)
      ST_LOAD: begin
        rd_req_d = 1'b1;
        if (rd_req_q && chip_rd_ack) begin
          rd_req_d = 1'b0;
          tm_d     = chip_rd_time;
          lost_d   = !(chip_rd_ok && time_ok(chip_rd_time));
          ord_d    = ord_s2_q;
          rxr_d    = 1'b1;
          st_d     = ST_RUN;
        end
      end
      ST_RUN: begin
        tick_d = tick_q + 1'b1;
        if (tick_q == TICK_W'(TICK_CYC - 1)) begin
          tick_d = '0;
          if (!lost_q) tm_d = advance(tm_q);
        end
        if (wr_req_q && chip_wr_ack) wr_req_d = 1'b0;
        if (rp_q && f_ready) begin
          rpos_d = (rpos_q == 2'd2) ? 2'd0 : rpos_q + 2'd1;
          if (rpos_q == 2'd2 && !last) rg_d = rg_q + 3'd1;
          if (last && rpos_q == 2'd2) rp_d = 1'b0;
        end
        if (take) begin
          if (is_up) begin
            rp_d  = 1'b0;
            set_d = (rx_data == CH_SET);
            hi_d  = 1'b0;
            dcnt_d = '0;
            if (rx_data == CH_REQ) begin
              for (int i = 0; i < NGRP; i++) snap_d[i] = cur[NGRP-1-i];
              rp_d   = 1'b1;
              rg_d   = '0;
              rpos_d = '0;
              bad_d  = lost_q || !time_ok(tm_q);
              if (lost_q || !time_ok(tm_q)) err_d = 1'b1;
            end
          end else if (set_q && is_dig) begin
            if (dcnt_q != MAX_DIGITS) dcnt_d = dcnt_q + 4'h1;
            else err_d = 1'b1;
            hi_d = !hi_q;
            hv_d = rx_data[3:0];
            if (hi_q) begin
              for (int i = NGRP - 1; i > 0; i--) grp_d[i] = grp_q[i-1];
              grp_d[0] = ({3'b000, hv_q} * 7'd10) + {3'b000, rx_data[3:0]};
            end
          end else if (set_q && is_dl) begin
            set_d = 1'b0;
            if (dcnt_q[0] || !time_ok(nt)) begin
              err_d = 1'b1;
            end else begin
              tm_d     = nt;
              tick_d   = '0;
              lost_d   = 1'b0;
              wr_d     = nt;
              wr_req_d = 1'b1;
            end
          end
        end
      end
      default: st_d = ST_LOAD;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_LOAD;  tm_q <= '0;  wr_q <= '0;  tick_q <= '0;
      ord_s1_q <= 1'b0;  ord_s2_q <= 1'b0;  ord_q <= 1'b0;
      lost_q <= 1'b1;  err_q <= 1'b0;  rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;  rxr_q <= 1'b0;  set_q <= 1'b0;
      hi_q <= 1'b0;  hv_q <= '0;  dcnt_q <= '0;
      rp_q <= 1'b0;  bad_q <= 1'b0;  rg_q <= '0;  rpos_q <= '0;
      for (int i = 0; i < NGRP; i++) begin
        grp_q[i]  <= '0;
        snap_q[i] <= '0;
      end
    end else begin
      st_q <= st_d;  tm_q <= tm_d;  wr_q <= wr_d;  tick_q <= tick_d;
      ord_s1_q <= date_us;  ord_s2_q <= ord_s1_q;  ord_q <= ord_d;
      lost_q <= lost_d;  err_q <= err_d;  rd_req_q <= rd_req_d;
      wr_req_q <= wr_req_d;  rxr_q <= rxr_d;  set_q <= set_d;
      hi_q <= hi_d;  hv_q <= hv_d;  dcnt_q <= dcnt_d;
      rp_q <= rp_d;  bad_q <= bad_d;  rg_q <= rg_d;  rpos_q <= rpos_d;
      grp_q <= grp_d;
      snap_q <= snap_d;
    end
  end

  assign rx_ready     = rxr_q;
  assign err          = err_q;
  assign chip_rd_req  = rd_req_q;
  assign chip_wr_req  = wr_req_q;
  assign chip_wr_time = wr_q;

endmodule

// ==== atr_clock_asserts.sv ====
// Concurrent checks on the ports of the ASCII time block.
`timescale 1ns/1ps

module atr_clock_asserts import atr_pkg::*; (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Host side
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic       err,
  input wire logic       err_clr,
  // Backup chip side
  input wire logic       chip_rd_req,
  input wire logic       chip_rd_ack,
  input wire logic       chip_wr_req,
  input wire atr_time_t  chip_wr_time,
  input wire logic       chip_wr_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic rx_take;
  assign rx_take = rx_valid && rx_ready;

  chk_rd_hold: assert property (chip_rd_req && !chip_rd_ack |=> chip_rd_req)
    else $error("backup read request dropped before its ack");
  chk_rd_done: assert property (chip_rd_req && chip_rd_ack |=> !chip_rd_req && rx_ready)
    else $error("load did not end after the read ack");
  chk_ready_stays: assert property (rx_ready |=> rx_ready)
    else $error("command port stopped taking bytes");
  chk_wr_hold: assert property (chip_wr_req && !chip_wr_ack && !rx_take
    |=> chip_wr_req && $stable(chip_wr_time))
    else $error("chip write changed before its ack");
  chk_tx_hold: assert property (tx_valid && !tx_ready && !rx_take
    |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed before it was taken");
  chk_lower_quiet: assert property (rx_take && rx_data >= 8'h61 && rx_data <= 8'h7a
    && !err_clr |=> !$rose(err) && !$rose(chip_wr_req))
    else $error("lowercase byte had an effect");
  chk_err_latch: assert property (err && !err_clr |=> err)
    else $error("error flag dropped without a clear");
  chk_upper_flush: assert property (rx_take && rx_data >= CH_A && rx_data <= CH_Z
    |=> !tx_valid)
    else $error("reply bytes survived a new instruction");

  cover property (chip_wr_req && chip_wr_ack);
  cover property (tx_valid && tx_ready && tx_data == CH_LF);
  cover property ($rose(err));
endmodule

bind atr_clock atr_clock_asserts atr_clock_asserts_inst (
  .sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .err(err), .err_clr(err_clr), .chip_rd_req(chip_rd_req), .chip_rd_ack(chip_rd_ack),
  .chip_wr_req(chip_wr_req), .chip_wr_time(chip_wr_time), .chip_wr_ack(chip_wr_ack));

// ==== atr_clock_tb_top.sv ====
// Self-checking testbench for the ASCII time set and request block.
`timescale 1ns/1ps

module atr_clock_tb_top;
  import atr_pkg::*;
  logic       sys_clk = 0, rst = 1, rx_valid = 0, tx_ready = 0;
  logic       date_us = 1, err_clr = 0, time_ok = 1;
  logic [7:0] rx_data = 8'h00;
  logic       rx_ready, tx_valid, err, chip_rd_req, chip_rd_ack, chip_rd_ok;
  logic       chip_wr_req, chip_wr_ack;
  logic [7:0] tx_data;
  atr_time_t  chip_rd_time, chip_wr_time;
  int         bad_count = 0;
  int         compares = 0;

  always #5 sys_clk = ~sys_clk;

  atr_clock #(.TICK_CYC(10)) atr_clock_inst (.sys_clk(sys_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .date_us(date_us), .err(err),
    .err_clr(err_clr), .chip_rd_req(chip_rd_req), .chip_rd_ack(chip_rd_ack),
    .chip_rd_time(chip_rd_time), .chip_rd_ok(chip_rd_ok), .chip_wr_req(chip_wr_req),
    .chip_wr_time(chip_wr_time), .chip_wr_ack(chip_wr_ack));

  atr_chip_model #(.BOOT_TIME({7'h07, 7'h0d, 7'h10, 7'h3a, 7'h11, 10'h000}))
  atr_chip_model_inst (.sys_clk(sys_clk), .rst(rst), .time_ok(time_ok),
    .chip_rd_req(chip_rd_req), .chip_rd_ack(chip_rd_ack), .chip_rd_time(chip_rd_time),
    .chip_rd_ok(chip_rd_ok), .chip_wr_req(chip_wr_req), .chip_wr_time(chip_wr_time),
    .chip_wr_ack(chip_wr_ack));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function atr_time_t tm(int mo, int d, int h, int mi, int s);
    return {7'(mo), 7'(d), 7'(h), 7'(mi), 7'(s), SET_COMP_MS};
  endfunction

  task do_reset(input logic us, input logic ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    rst = 1;
    date_us = us;
    time_ok = ok;
    repeat (10) @(negedge sys_clk);
    rst = 0;
    while (rx_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check(rx_ready, 1);
  endtask

  task send_str(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      @(negedge sys_clk);
      rx_valid = 1;
      rx_data = s[i];
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 100);
      check(rx_ready, 1);
    end
    @(negedge sys_clk);
    rx_valid = 0;
    rx_data = ~rx_data;
  endtask

  task read_byte(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    tx_ready = 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 200);
    check(tx_valid, 1);
    check(tx_data, exp);
  endtask

  task expect_reply(input int g0, g1, g2, g3, g4, input int n);
    int g[5];
    g = '{g0, g1, g2, g3, g4};
    for (int i = 0; i < n; i++) begin
      read_byte(CH_0 + 8'(g[i] / 10));
      read_byte(CH_0 + 8'(g[i] % 10));
      read_byte(i == n - 1 ? CH_LF : CH_COL);
    end
    @(negedge sys_clk);
    tx_ready = 0;
  endtask

  task wait_wr(input atr_time_t exp);
    int n;
    n = 0;
    while (chip_wr_req !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    check(chip_wr_req, 1);
    check(chip_wr_time, exp);
    while (chip_wr_req === 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check(chip_wr_req, 0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_set_req;
    send_str("Sset06b15 23:59:58/");
    wait_wr(tm(6, 15, 23, 59, 58));
    send_str("R");
    repeat (20) @(negedge sys_clk);
    expect_reply(6, 15, 23, 59, 58, 5);
    send_str("S4217\n");
    wait_wr(tm(6, 15, 23, 42, 17));
    $display("set and request done");
  endtask

  task t_errors;
    string bad[6];
    bad = '{"S123/", "S0431120000/", "S1301000000/", "S240000/", "S60/", "S31120000/"};
    foreach (bad[i]) begin
      send_str(bad[i]);
      repeat (3) @(negedge sys_clk);
      check(err, 1);
      check(chip_wr_req, 0);
      err_clr = 1;
      @(negedge sys_clk);
      err_clr = 0;
      check(err, 0);
    end
    send_str("R");
    expect_reply(6, 15, 23, 42, 17, 5);
    send_str("S0229000000/");
    wait_wr(tm(2, 29, 0, 0, 0));
    check(err, 0);
    $display("range errors done");
  endtask

  task t_abort;
    send_str("R");
    read_byte(CH_0);
    read_byte(8'h32);
    @(negedge sys_clk);
    tx_ready = 0;
    send_str("Q");
    repeat (5) @(negedge sys_clk);
    check(tx_valid, 0);
    $display("reply abort done");
  endtask

  task t_wrap;
    send_str("S0228235959/");
    wait_wr(tm(2, 28, 23, 59, 59));
    repeat (10000) @(negedge sys_clk);
    send_str("R");
    expect_reply(3, 1, 0, 0, 0, 5);
    $display("day wrap done");
  endtask

  task t_order_lost;
    do_reset(0, 1);
    send_str("R");
    expect_reply(13, 7, 16, 58, 17, 5);
    send_str("S3112235900/");
    wait_wr(tm(12, 31, 23, 59, 0));
    do_reset(1, 0);
    send_str("R");
    expect_reply(88, 88, 88, 88, 0, 4);
    check(err, 1);
    $display("order and lost time done");
  endtask

  initial begin
    do_reset(1, 1);
    t_set_req;
    t_errors;
    t_abort;
    t_wrap;
    t_order_lost;
    print_verdict;
  end

  initial begin
    #500000;
    bad_count++;
    print_verdict;
  end
endmodule

// ==== atr_pkg.sv ====
// Shared constants and types for the ASCII time set and request block.
package atr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_A   = 8'h41;
  localparam logic [7:0] CH_Z   = 8'h5a;
  localparam logic [7:0] CH_0   = 8'h30;
  localparam logic [7:0] CH_9   = 8'h39;
  localparam logic [7:0] CH_8   = 8'h38;
  localparam logic [7:0] CH_EQ  = 8'h3d;
  localparam logic [7:0] CH_SL  = 8'h2f;
  localparam logic [7:0] CH_LF  = 8'h0a;
  localparam logic [7:0] CH_COL = 8'h3a;
  localparam logic [7:0] CH_SET = 8'h53;
  localparam logic [7:0] CH_REQ = 8'h52;

  // ----------------------------------------------------------------
  // Limits and counts
  // ----------------------------------------------------------------
  localparam logic [9:0] MS_MAX      = 10'h3e7;
  localparam logic [9:0] SET_COMP_MS = 10'h00a;
  localparam logic [6:0] SEC_MAX     = 7'h3b;
  localparam logic [6:0] HR_MAX      = 7'h17;
  localparam logic [6:0] MON_MAX     = 7'h0c;
  localparam logic [6:0] DAY_LONG    = 7'h1f;
  localparam logic [6:0] DAY_SHORT   = 7'h1e;
  localparam logic [6:0] DAY_FEB_SET = 7'h1d;
  localparam logic [6:0] DAY_FEB_RUN = 7'h1c;
  localparam logic [3:0] MAX_DIGITS  = 4'ha;
  localparam int         NGRP        = 5;
  localparam int         FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] mon;
    logic [6:0] day;
    logic [6:0] hr;
    logic [6:0] min;
    logic [6:0] sec;
    logic [9:0] ms;
  } atr_time_t;

  typedef enum logic {ST_LOAD, ST_RUN} atr_state_t;

endpackage
